// ===== core/acic_regs.svh
`ifndef ACIC_REGS_SVH
`define ACIC_REGS_SVH

// Register offsets on the four-bit word address.
`define ACIC_OFF_CFG        4'h8
`define ACIC_OFF_EN         4'h9
`define ACIC_OFF_STAT       4'hA
`define ACIC_OFF_FIFO       4'hC
`define ACIC_OFF_LIM        4'hD

// Configuration register bit positions.
`define ACIC_CFG_START      0
`define ACIC_CFG_RESET      1
`define ACIC_CFG_AZ         2
`define ACIC_CFG_STBY       4
`define ACIC_CFG_TAGMASK    5
`define ACIC_CFG_AZALL      6
`define ACIC_CFG_SYNCDIR    7
`define ACIC_CFG_SECT_LO    8
`define ACIC_CFG_TEST       10
`define ACIC_CFG_DIAG       11
`define ACIC_CFG_WMASK      16'h0FF9

// Instruction fields, section one and the limit sections.
`define ACIC_INS_PLUS_LO    2
`define ACIC_INS_MINUS_LO   5
`define ACIC_INS_SYNC       8
`define ACIC_INS_WATCH      11
`define ACIC_LIM_SIGN       8
`define ACIC_LIM_DIR        9

// Reset values and encodings.
`define ACIC_CFG_RST        16'h0000
`define ACIC_EN_RST         16'h0000
`define ACIC_DIAG_REF_SEL   3'h1
`define ACIC_FIFO_DEPTH     6'h20

// Timing.
`define ACIC_CLK_MHZ        100
`define ACIC_AZ_CYCLES      7'h4C
`define ACIC_RST_CYCLES     2'h2
`define ACIC_STBY_SETTLE_MS 10
`define ACIC_STBY_SETTLE_CYC (`ACIC_STBY_SETTLE_MS * 1000 * `ACIC_CLK_MHZ)

`endif

// ===== core/acic_pkg.sv
`default_nettype none
package acic_pkg;
   typedef logic [15:0] acic_word_t;
   typedef enum logic [2:0] {
      ACIC_S_IDLE, ACIC_S_FETCH, ACIC_S_AZ, ACIC_S_SYNC,
      ACIC_S_CONV, ACIC_S_CMP1, ACIC_S_CMP2, ACIC_S_NEXT
   } acic_seq_e;
endpackage
`default_nettype wire

// ===== core/acic_irq_if.sv
`default_nettype none
interface acic_irq_if;
   logic [7:0] set;
   logic       rd_clr;
   logic       clr_all;
   logic [7:0] en;
   logic [7:0] flags;
   logic       int_n;
   modport ctl (output set, output rd_clr, output clr_all, output en, input flags, input int_n);
   modport irq (input set, input rd_clr, input clr_all, input en, output flags, output int_n);
endinterface
`default_nettype wire

// ===== core/acic_irq.sv
`default_nettype none
module acic_irq
   import acic_pkg::*;
(
   // Clock and reset.
   input  wire logic clock_i,
   input  wire logic resetn_i,
   // Flag control.
   acic_irq_if.irq   bus
);

   // Sticky flags: a new event in the clearing cycle survives the read.
   always_ff @(posedge clock_i) begin
      if (!resetn_i || bus.clr_all) begin
         bus.flags <= 8'h00;
      end else begin
         bus.flags <= (bus.rd_clr ? 8'h00 : bus.flags) | bus.set; // RL25
      end
   end

   // Pin is low while any enabled flag stands.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         bus.int_n <= 1'b1;
      end else begin
         bus.int_n <= ~|(bus.flags & bus.en); // RL15 RL26
      end
   end

   AST_INT_PIN: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL26
      ##1 (bus.int_n == ~|($past(bus.flags) & $past(bus.en))))
      else $error("interrupt pin does not follow enabled flags");
   AST_SET_WINS: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL25
      (bus.set[0] && !bus.clr_all) |=> bus.flags[0])
      else $error("flag lost in clearing cycle");

endmodule // acic_irq
`default_nettype wire

// ===== core/acic_top.sv
// How it works
// RL1: Standby gates clock, lowers analog power, keeps RAM; code holds the sequencer and FIFO in system reset instead of gating the clock.
// RL2: Leaving standby equals a system reset.
// RL3: Standby-completion interrupt after settling delay.
// RL4: Instruction RAM stays accessible during standby.
// RL5: Tag mask fills FIFO bits 13-15 with sign.
// RL6: Otherwise FIFO bits 13-15 carry instruction pointer.
// RL7: Optional auto-zero before every conversion or compare.
// RL8: Sync direction bit selects pin output or input.
// RL9: Rising sync edge starts the operation.
// RL10: Sync output high for whole operation.
// RL11: Section pointer selects instruction sixteen-bit third.
// RL12: Host keeps the test bit cleared.
// RL13: Diagnostic bit reroutes inputs, needs test clear.
// RL14: Diagnostic code 001 both selects reference pair.
// RL15: Eight equal sources, unmasked ones drive pin low.
// RL16: Host reads status after enable writes.
// RL17: Watch instruction compares sample twice, flags interrupt 0.
// RL18: Limit direction bit selects above or below.
// RL19: Limit status records limit and instruction.
// RL20: Interrupt 1 on instruction address match, pre-execution; code skips a match at address 0 on the first fetch after reset.
// RL21: Interrupt 2 when FIFO count equals threshold.
// RL22: Interrupt 3 when short auto-zero completes.
// RL23: Config bit 4 enters standby, clearing leaves.
// RL24: System reset stops, zeroes pointer, empties FIFO, flags.
// RL25: Status flags clear on read or reset.
// RL26: Pin low while any enabled flag set.
`include "acic_regs.svh"
`default_nettype none
module acic_top
   import acic_pkg::*;
#(
   parameter int unsigned STBY_SETTLE_CYC = `ACIC_STBY_SETTLE_CYC
)(
   // Clock and reset.
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   // Parallel register bus.
   input  wire logic [3:0]  addr_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [15:0] wdata_i,
   output logic      [15:0] rdata_o,
   // Converter front end.
   output logic             adc_start_o,
   input  wire logic        adc_done_i,
   input  wire logic [12:0] adc_data_i,
   output logic      [2:0]  mux_plus_o,
   output logic      [2:0]  mux_minus_o,
   output logic             diag_o,
   output logic             ref_pair_o,
   output logic             az_active_o,
   output logic             standby_o,
   // Sync pin and other interrupt sources.
   input  wire logic        sync_i,
   output logic             sync_o,
   output logic             sync_oe_o,
   input  wire logic [2:0]  aux_event_i,
   output logic             int_n_o
);

   acic_irq_if  irq_bus ();
   acic_seq_e   state_reg;
   acic_word_t  cfg_reg;
   acic_word_t  en_reg;
   logic [47:0] ram [0:7];
   logic [15:0] fifo_mem [0:31];
   logic [4:0]  wr_ptr_reg, rd_ptr_reg;
   logic [5:0]  cnt_reg;
   logic [1:0]  rst_cnt_reg;
   logic [31:0] settle_reg;
   logic        settle_run_reg;
   logic [6:0]  az_cnt_reg;
   logic        az_req_reg, az_cmd_reg;
   logic [2:0]  ip_reg;
   logic        fetched_reg;
   logic [12:0] sample_reg;
   logic [15:0] lim_stat_reg;
   logic        push_reg;
   logic [15:0] push_data_reg;
   logic        int0_reg, int1_reg, int2_reg, int3_reg, int7_reg;
   logic        sync_q_reg;
   logic        sys_rst, wr_cfg, stby_exit, pop, sync_rise, is_ram;
   logic [47:0] ins;
   logic [1:0]  sect;

   // Returns true for a strobe addressed to one register.
   function automatic logic hit(input logic strobe, input logic [3:0] a, input logic [3:0] off);
      hit = strobe && (a == off);
   endfunction

   // Compares the sample against one limit section in its direction.
   function automatic logic lim_hit(input logic [12:0] s, input logic [15:0] l);
      logic signed [9:0] smp;
      logic signed [9:0] lim;
      smp = {s[12], s[12:4]};
      lim = l[`ACIC_LIM_SIGN] ? -$signed({2'b00, l[7:0]}) : $signed({2'b00, l[7:0]});
      lim_hit = l[`ACIC_LIM_DIR] ? (smp > lim) : (smp < lim); // RL18
   endfunction

   // Bus decode and the shared resets.
   assign is_ram    = !addr_i[3];
   assign sect      = cfg_reg[`ACIC_CFG_SECT_LO +: 2];
   assign wr_cfg    = hit(wr_i, addr_i, `ACIC_OFF_CFG);
   assign stby_exit = wr_cfg && cfg_reg[`ACIC_CFG_STBY] && !wdata_i[`ACIC_CFG_STBY];
   assign sys_rst   = (rst_cnt_reg != 2'h0) || cfg_reg[`ACIC_CFG_STBY]; // RL1 RL2
   assign pop       = hit(rd_i, addr_i, `ACIC_OFF_FIFO) && (cnt_reg != 6'h00);
   assign sync_rise = sync_i && !sync_q_reg;
   assign ins       = ram[ip_reg];

   // Interrupt flag block hookup.
   assign irq_bus.set     = {int7_reg, aux_event_i, int3_reg, int2_reg, int1_reg, int0_reg};
   assign irq_bus.rd_clr  = hit(rd_i, addr_i, `ACIC_OFF_STAT); // RL25
   assign irq_bus.clr_all = sys_rst; // RL24
   assign irq_bus.en      = en_reg[7:0];
   assign int_n_o         = irq_bus.int_n;

   acic_irq u_irq (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .bus      (irq_bus)
   );

   // Configuration and enable registers with the self-clearing reset bit.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         cfg_reg     <= `ACIC_CFG_RST;
         en_reg      <= `ACIC_EN_RST;
         rst_cnt_reg <= 2'h0;
      end else begin
         if (wr_cfg) begin
            cfg_reg <= wdata_i & `ACIC_CFG_WMASK; // RL23 RL11
         end else if (sys_rst) begin
            cfg_reg[`ACIC_CFG_START] <= 1'b0; // RL24
         end
         if (hit(wr_i, addr_i, `ACIC_OFF_EN)) begin
            en_reg <= wdata_i;
         end
         if ((wr_cfg && wdata_i[`ACIC_CFG_RESET]) || stby_exit) begin
            rst_cnt_reg <= `ACIC_RST_CYCLES; // RL2
         end else if (rst_cnt_reg != 2'h0) begin
            rst_cnt_reg <= rst_cnt_reg - 2'h1;
         end
      end
   end

   // Instruction RAM, one section per access, kept through standby.
   always_ff @(posedge clock_i) begin
      if (wr_i && is_ram && sect != 2'b11) begin
         ram[addr_i[2:0]][sect*16 +: 16] <= wdata_i; // RL4 RL11
      end
   end

   // Settling delay after standby exit, then the completion flag.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         settle_reg     <= 32'h0000_0000;
         settle_run_reg <= 1'b0;
         int7_reg       <= 1'b0;
      end else begin
         int7_reg <= 1'b0;
         if (stby_exit) begin
            settle_reg     <= STBY_SETTLE_CYC - 1;
            settle_run_reg <= 1'b1;
         end else if (settle_run_reg) begin
            if (settle_reg == 32'h0000_0000) begin
               settle_run_reg <= 1'b0;
               int7_reg       <= 1'b1; // RL3
            end else begin
               settle_reg <= settle_reg - 32'h0000_0001;
            end
         end
      end
   end

   // Conversion FIFO with the count-threshold event.
   always_ff @(posedge clock_i) begin
      if (!resetn_i || sys_rst) begin
         wr_ptr_reg <= 5'h00;
         rd_ptr_reg <= 5'h00;
         cnt_reg    <= 6'h00; // RL24
         int2_reg   <= 1'b0;
      end else begin
         int2_reg <= 1'b0;
         if (push_reg && cnt_reg != `ACIC_FIFO_DEPTH) begin
            fifo_mem[wr_ptr_reg] <= push_data_reg;
            wr_ptr_reg           <= wr_ptr_reg + 5'h01;
            if (cnt_reg + 6'h01 - {5'h00, pop} == {1'b0, en_reg[15:11]}) begin
               int2_reg <= (en_reg[15:11] != 5'h00); // RL21
            end
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 5'h01;
         end
         cnt_reg <= cnt_reg + {5'h00, push_reg && cnt_reg != `ACIC_FIFO_DEPTH} - {5'h00, pop};
      end
   end

   // Sync pin sampling and direction.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         sync_q_reg <= 1'b0;
         sync_oe_o  <= 1'b0;
         standby_o  <= 1'b0;
         diag_o     <= 1'b0;
      end else begin
         sync_q_reg <= sync_i;
         sync_oe_o  <= cfg_reg[`ACIC_CFG_SYNCDIR]; // RL8
         standby_o  <= cfg_reg[`ACIC_CFG_STBY]; // RL1
         diag_o     <= cfg_reg[`ACIC_CFG_DIAG] && !cfg_reg[`ACIC_CFG_TEST]; // RL13
      end
   end

   // Instruction sequencer, halted and cleared by the system reset.
   always_ff @(posedge clock_i) begin
      if (!resetn_i || sys_rst) begin
         state_reg     <= ACIC_S_IDLE;
         ip_reg        <= 3'h0; // RL24
         fetched_reg   <= 1'b0;
         az_req_reg    <= 1'b0;
         az_cmd_reg    <= 1'b0;
         az_cnt_reg    <= 7'h00;
         az_active_o   <= 1'b0;
         sample_reg    <= 13'h0000;
         lim_stat_reg  <= 16'h0000;
         push_reg      <= 1'b0;
         push_data_reg <= 16'h0000;
         adc_start_o   <= 1'b0;
         sync_o        <= 1'b0;
         mux_plus_o    <= 3'h0;
         mux_minus_o   <= 3'h0;
         ref_pair_o    <= 1'b0;
         int0_reg      <= 1'b0;
         int1_reg      <= 1'b0;
         int3_reg      <= 1'b0;
      end else begin
         adc_start_o <= 1'b0;
         push_reg    <= 1'b0;
         int0_reg    <= 1'b0;
         int1_reg    <= 1'b0;
         int3_reg    <= 1'b0;
         if (wr_cfg && wdata_i[`ACIC_CFG_AZ]) begin
            az_req_reg <= 1'b1;
         end
         if (hit(rd_i, addr_i, `ACIC_OFF_LIM)) begin
            lim_stat_reg <= 16'h0000;
         end
         case (state_reg)
            ACIC_S_IDLE: begin
               if (az_req_reg) begin
                  az_cmd_reg  <= 1'b1;
                  az_cnt_reg  <= `ACIC_AZ_CYCLES - 7'h01;
                  az_active_o <= 1'b1;
                  state_reg   <= ACIC_S_AZ;
               end else if (cfg_reg[`ACIC_CFG_START]) begin
                  state_reg <= ACIC_S_FETCH;
               end
            end
            ACIC_S_FETCH: begin
               fetched_reg <= 1'b1;
               int1_reg    <= (ip_reg == en_reg[10:8]) && (fetched_reg || ip_reg != 3'h0); // RL20
               mux_plus_o  <= ins[`ACIC_INS_PLUS_LO +: 3];
               mux_minus_o <= ins[`ACIC_INS_MINUS_LO +: 3];
               ref_pair_o  <= diag_o && ins[`ACIC_INS_PLUS_LO +: 3] == `ACIC_DIAG_REF_SEL
                              && ins[`ACIC_INS_MINUS_LO +: 3] == `ACIC_DIAG_REF_SEL; // RL14
               if (cfg_reg[`ACIC_CFG_AZALL]) begin
                  az_cmd_reg  <= 1'b0;
                  az_cnt_reg  <= `ACIC_AZ_CYCLES - 7'h01;
                  az_active_o <= 1'b1;
                  state_reg   <= ACIC_S_AZ; // RL7
               end else begin
                  state_reg <= ACIC_S_SYNC;
               end
            end
            ACIC_S_AZ: begin
               if (az_cnt_reg == 7'h00) begin
                  az_active_o <= 1'b0;
                  if (az_cmd_reg) begin
                     az_req_reg <= 1'b0;
                     int3_reg   <= 1'b1; // RL22
                     state_reg  <= ACIC_S_IDLE;
                  end else begin
                     state_reg <= ACIC_S_SYNC;
                  end
               end else begin
                  az_cnt_reg <= az_cnt_reg - 7'h01;
               end
            end
            ACIC_S_SYNC: begin
               if (!ins[`ACIC_INS_SYNC] || cfg_reg[`ACIC_CFG_SYNCDIR] || sync_rise) begin // RL9
                  adc_start_o <= 1'b1;
                  sync_o      <= cfg_reg[`ACIC_CFG_SYNCDIR]; // RL10
                  state_reg   <= ACIC_S_CONV;
               end
            end
            ACIC_S_CONV: begin
               if (adc_done_i) begin
                  sample_reg <= adc_data_i;
                  if (ins[`ACIC_INS_WATCH]) begin
                     state_reg <= ACIC_S_CMP1; // RL17
                  end else begin
                     push_reg      <= 1'b1;
                     push_data_reg <= {cfg_reg[`ACIC_CFG_TAGMASK] ? {3{adc_data_i[12]}} : ip_reg,
                                       adc_data_i}; // RL5 RL6
                     state_reg     <= ACIC_S_NEXT;
                  end
               end
            end
            ACIC_S_CMP1: begin
               if (lim_hit(sample_reg, ins[31:16])) begin
                  lim_stat_reg[ip_reg] <= 1'b1; // RL19
                  int0_reg             <= 1'b1; // RL17
               end
               state_reg <= ACIC_S_CMP2;
            end
            ACIC_S_CMP2: begin
               if (lim_hit(sample_reg, ins[47:32])) begin
                  lim_stat_reg[{1'b1, ip_reg}] <= 1'b1; // RL19
                  int0_reg                     <= 1'b1; // RL17
               end
               state_reg <= ACIC_S_NEXT;
            end
            ACIC_S_NEXT: begin
               sync_o    <= 1'b0; // RL10
               ip_reg    <= ip_reg + 3'h1;
               state_reg <= ACIC_S_IDLE;
            end
            default: begin
               state_reg <= ACIC_S_IDLE;
            end
         endcase
      end
   end

   // Registered read data.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         if (is_ram) begin
            rdata_o <= (sect == 2'b11) ? 16'h0000 : ram[addr_i[2:0]][sect*16 +: 16];
         end else begin
            case (addr_i)
               `ACIC_OFF_CFG:  rdata_o <= {cfg_reg[15:3], az_req_reg, sys_rst,
                                           state_reg != ACIC_S_IDLE || cfg_reg[0]};
               `ACIC_OFF_EN:   rdata_o <= en_reg;
               `ACIC_OFF_STAT: rdata_o <= {cnt_reg[4:0], ip_reg, irq_bus.flags};
               `ACIC_OFF_FIFO: rdata_o <= fifo_mem[rd_ptr_reg];
               `ACIC_OFF_LIM:  rdata_o <= lim_stat_reg;
               default:        rdata_o <= 16'h0000;
            endcase
         end
      end
   end

   AST_STBY_RESET: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL1
      standby_o |-> (state_reg == ACIC_S_IDLE && cnt_reg == 6'h00))
      else $error("logic active during standby");
   AST_EXIT_RESET: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL2
      stby_exit |=> sys_rst [*2] ##1 !sys_rst)
      else $error("standby exit without two-cycle reset");
   AST_TAG_SIGN: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL5
      (push_reg && cfg_reg[`ACIC_CFG_TAGMASK]) |-> (push_data_reg[15:13] == {3{push_data_reg[12]}}))
      else $error("masked tag not sign filled");
   AST_SYNC_DIR: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL8
      ##1 (sync_oe_o == $past(cfg_reg[`ACIC_CFG_SYNCDIR])))
      else $error("sync enable mismatch");
   AST_SYNC_HOLD: assert property (@(posedge clock_i) disable iff (!resetn_i || sys_rst) // RL10
      (state_reg == ACIC_S_CONV && cfg_reg[`ACIC_CFG_SYNCDIR]) |-> sync_o)
      else $error("sync output dropped during operation");
   AST_AZ_LEN: assert property (@(posedge clock_i) disable iff (!resetn_i || sys_rst) // RL22
      $rose(az_active_o) && az_cmd_reg |-> ##75 az_active_o ##1 (int3_reg && !az_active_o))
      else $error("short auto-zero length wrong");
   AST_IP_MATCH: assert property (@(posedge clock_i) disable iff (!resetn_i || sys_rst) // RL20
      int1_reg |-> ($past(ip_reg) == en_reg[10:8] && state_reg != ACIC_S_FETCH))
      else $error("instruction interrupt at wrong address");
   AST_RESET_CLR: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL24
      sys_rst |=> (ip_reg == 3'h0 && irq_bus.flags == 8'h00 && cnt_reg == 6'h00))
      else $error("system reset incomplete");

   COV_WATCH: cover property (@(posedge clock_i) disable iff (!resetn_i) int0_reg);
   COV_FIFO_THR: cover property (@(posedge clock_i) disable iff (!resetn_i) int2_reg);
   COV_STBY_DONE: cover property (@(posedge clock_i) disable iff (!resetn_i) int7_reg);
   COV_SYNC_START: cover property (@(posedge clock_i) disable iff (!resetn_i)
      state_reg == ACIC_S_SYNC && sync_rise);

endmodule // acic_top
`default_nettype wire

// ===== bench/acic_fe_model.sv
`default_nettype none
module acic_fe_model #(
   parameter int DLY = 5
)(
   // Clock and start request.
   input  wire logic        clock_i,
   input  wire logic        start_i,
   input  wire logic [12:0] value_i,
   // Result back to the block.
   output wire logic        done_o,
   output wire logic [12:0] data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   // Each start is answered after DLY cycles by a one-cycle result.
   always @(posedge clock_i) begin
      cnt <= start_i ? DLY : (cnt > 0 ? cnt - 1 : 0);
   end
   // Outside the result cycle the data lines show the inverse value.
   assign done_o = (cnt == 1);
   assign data_o = done_o ? value_i : ~value_i;
endmodule // acic_fe_model
`default_nettype wire

// ===== bench/tb.sv
`include "acic_regs.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import acic_pkg::*;
   // Register offsets used by the sequences.
   localparam logic [3:0] cfg_a = `ACIC_OFF_CFG;
   localparam logic [3:0] en_a  = `ACIC_OFF_EN;
   localparam logic [3:0] st_a  = `ACIC_OFF_STAT;
   localparam logic [3:0] ff_a  = `ACIC_OFF_FIFO;
   localparam logic [3:0] lim_a = `ACIC_OFF_LIM;
   // Design pins and bench state.
   logic        clock_i     = 1'b0;
   logic        resetn_i    = 1'b0;
   logic [3:0]  addr_i      = 4'h0;
   logic        wr_i        = 1'b0;
   logic        rd_i        = 1'b0;
   logic [15:0] wdata_i     = 16'h0000;
   logic        sync_i      = 1'b0;
   logic [2:0]  aux_event_i = 3'h0;
   logic [12:0] value       = 13'h1ABC;
   logic [15:0] rdata_o, v;
   logic [12:0] adc_data_i;
   logic [2:0]  mux_plus_o, mux_minus_o;
   logic        adc_start_o, adc_done_i, diag_o, ref_pair_o, az_active_o;
   logic        standby_o, sync_o, sync_oe_o, int_n_o;
   int          fail_count = 0;
   int          n_tests    = 0;
   int          n;
   // The 100 MHz clock.
   always #5 clock_i = ~clock_i;
   // Block under test, with a short standby settle count.
   acic_top #(.STBY_SETTLE_CYC(20)) acic_top_inst (
      .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
      .wdata_i(wdata_i), .rdata_o(rdata_o), .adc_start_o(adc_start_o),
      .adc_done_i(adc_done_i), .adc_data_i(adc_data_i), .mux_plus_o(mux_plus_o),
      .mux_minus_o(mux_minus_o), .diag_o(diag_o), .ref_pair_o(ref_pair_o),
      .az_active_o(az_active_o), .standby_o(standby_o), .sync_i(sync_i), .sync_o(sync_o),
      .sync_oe_o(sync_oe_o), .aux_event_i(aux_event_i), .int_n_o(int_n_o));
   // Converter front end.
   acic_fe_model acic_fe_model_inst (.clock_i(clock_i), .start_i(adc_start_o),
      .value_i(value), .done_o(adc_done_i), .data_o(adc_data_i));
   // Verdict and end of run.
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Compares one result and counts it.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bus cycles: one strobe cycle each, read data taken once settled.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(negedge clock_i);
      addr_i = a;
      wdata_i = d;
      wr_i = 1'b1;
      @(negedge clock_i);
      wr_i = 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(negedge clock_i);
      addr_i = a;
      rd_i = 1'b1;
      @(negedge clock_i);
      rd_i = 1'b0;
      @(negedge clock_i);
      v = rdata_o;
   endtask
   task automatic rc(input logic [3:0] a, input logic [15:0] e);
      rd(a);
      chk(v, e);
   endtask
   // Fills one section of all eight instructions.
   task automatic setall(input logic [1:0] s, input logic [15:0] w);
      wr(cfg_a, {6'h00, s, 8'h00});
      for (int i = 0; i < 8; i++) wr(i[3:0], w);
   endtask
   // Soft reset through the configuration register.
   task automatic sreset();
      wr(cfg_a, 16'h0002);
      repeat (3) @(negedge clock_i);
   endtask
   // Bounded wait: interrupt pin low, or a conversion start.
   task automatic wt(input bit s);
      int k;
      k = 0;
      while ((s ? adc_start_o : ~int_n_o) !== 1'b1 && k < 3000) begin
         @(negedge clock_i);
         k++;
      end
      if (k == 3000) begin
         fail_count++;
         $display("Error at %0t: wait timed out", $time);
         close_out();
      end
   endtask
   // Main sequence.
   initial begin
      repeat (16) @(negedge clock_i);
      resetn_i = 1'b1;
      rc(cfg_a, 16'h0000);
      rc(st_a, 16'h0000);
      rc(4'hF, 16'h0000);
      chk(int_n_o, 1'b1);
      // Each pointer value reaches its own third; the fourth is empty.
      for (int s = 0; s < 4; s++) begin
         wr(cfg_a, 16'(s << 8));
         wr(4'h5, 16'h0150 + 16'(s));
      end
      for (int s = 0; s < 4; s++) begin
         wr(cfg_a, 16'(s << 8));
         rc(4'h5, s == 3 ? 16'h0000 : 16'h0150 + 16'(s));
      end
      // Standby keeps the RAM open; leaving it flags completion later.
      wr(en_a, 16'h0080);
      rd(st_a);
      wr(cfg_a, 16'h0110);
      @(negedge clock_i);
      chk(standby_o, 1'b1);
      wr(4'h2, 16'h0033);
      rc(4'h2, 16'h0033);
      wr(cfg_a, 16'h0000);
      @(negedge clock_i);
      chk(standby_o, 1'b0);
      wt(0);
      rc(st_a, 16'h0080);
      rc(st_a, 16'h0000);
      chk(int_n_o, 1'b1);
      // Stored words carry the pointer, or sign copies when masked.
      setall(2'd0, 16'h000C);
      wr(en_a, 16'h1104);
      rd(st_a);
      wr(cfg_a, 16'h0081);
      wt(1);
      @(negedge clock_i);
      chk(sync_o, 1'b1);
      chk(sync_oe_o, 1'b1);
      chk(mux_plus_o, 3'h3);
      wt(0);
      wr(cfg_a, 16'h0080);
      repeat (20) @(negedge clock_i);
      chk(sync_o, 1'b0);
      rd(st_a);
      chk(v[2], 1'b1);
      chk(v[1], 1'b1);
      rc(ff_a, 16'h1ABC);
      rc(ff_a, 16'h3ABC);
      sreset();
      rc(st_a, 16'h0000);
      wr(cfg_a, 16'h0021);
      wt(0);
      wr(cfg_a, 16'h0020);
      repeat (20) @(negedge clock_i);
      rc(ff_a, 16'hFABC);
      // The per-conversion auto-zero runs its full length before a start.
      sreset();
      wr(cfg_a, 16'h0041);
      n = 0;
      for (int i = 0; i < 300 && adc_start_o !== 1'b1; i++) begin
         @(negedge clock_i);
         if (az_active_o === 1'b1) n++;
      end
      chk(16'(n), 16'h004C);
      // A commanded auto-zero raises its own flag.
      sreset();
      wr(en_a, 16'h0008);
      rd(st_a);
      wr(cfg_a, 16'h0004);
      wt(0);
      rc(st_a, 16'h0008);
      // Only enabled flags pull the pin; a read clears them.
      wr(en_a, 16'h0010);
      rd(st_a);
      aux_event_i = 3'h3;
      @(negedge clock_i);
      aux_event_i = 3'h4;
      @(negedge clock_i);
      aux_event_i = 3'h0;
      repeat (3) @(negedge clock_i);
      chk(int_n_o, 1'b0);
      rc(st_a, 16'h0070);
      chk(int_n_o, 1'b1);
      aux_event_i = 3'h4;
      @(negedge clock_i);
      aux_event_i = 3'h0;
      repeat (3) @(negedge clock_i);
      chk(int_n_o, 1'b1);
      rc(st_a, 16'h0040);
      // Diagnostic routing with the test bit clear selects the reference pair.
      setall(2'd0, 16'h0024);
      wr(cfg_a, 16'h0801);
      wt(1);
      chk(diag_o, 1'b1);
      chk(ref_pair_o, 1'b1);
      chk(mux_minus_o, 3'h1);
      wr(cfg_a, 16'h0000);
      @(negedge clock_i);
      chk(diag_o, 1'b0);
      sreset();
      // A waiting instruction starts only on a rising sync edge.
      setall(2'd0, 16'h010C);
      wr(cfg_a, 16'h0001);
      n = 0;
      repeat (30) begin
         @(negedge clock_i);
         if (adc_start_o === 1'b1) n++;
      end
      chk(16'(n), 16'h0000);
      chk(sync_oe_o, 1'b0);
      sync_i = 1'b1;
      wt(1);
      sync_i = 1'b0;
      sreset();
      // One sample checked against a limit above and a limit below.
      setall(2'd1, 16'h0200);
      setall(2'd2, 16'h00FF);
      setall(2'd0, 16'h080C);
      value = 13'h0100;
      wr(cfg_a, 16'h0001);
      wt(1);
      wr(cfg_a, 16'h0000);
      repeat (20) @(negedge clock_i);
      rd(st_a);
      chk(v[7:0], 8'h01);
      rc(lim_a, 16'h0101);
      close_out();
   end
endmodule // tb
`default_nettype wire
